/* core/eifl_cfg.svh */
// Constants for the maskable request and flag logic
//------------------------------------------------------------
// Notes on behaviour
// - Request pin is low-level sensed when edge select is 0, falling-edge when 1.
// - Edge select accepts one write only, within 64 clocks after reset.
// - Reset clears edge select, giving low-level wired-OR operation.
// - An event sets its flag; set and enabled flag holds a steady request.
// - Request stays until the flag is cleared, then it is withdrawn.
// - Falling-edge mode latches a request on a high-to-low pin transition.
// - Falling-edge mode stores only that an edge occurred, not its source.
// - No new edge is seen while the pin is already held low.
// - Request pin and strobe A handshake source share one vector.
// - Expanded modes hand the 18 handshake pins to the expansion bus.
// - Expanded modes decode handshake register addresses as external accesses.
// - Each maskable source but the request pin has its own flag and enable; enable gates its request.
// - Global mask set inhibits every maskable request.
// - Timer flags clear only on writing 1; writing 0 leaves them.
// - Receive-full clears on status read while set, then data read.
// - Read phase of the clear instruction counts as a register read.
// - Three capture pins are edge inputs, own edge select and vector.
// - Strobe A is an edge interrupt input in single-chip mode only.
// - Pulse accumulator pin is an extra edge-sensitive source.
// - A separate non-maskable request pin exists beside the maskable one.
// - Masked requests still become pending and are served after unmask.
//------------------------------------------------------------
`ifndef EIFL_CFG_SVH
`define EIFL_CFG_SVH

`define EIFL_OPT_WINDOW_CYC 7'h40
`define EIFL_CNT_W          7
`define EIFL_OPT_RST        1'b0
`define EIFL_HS_PIN_CNT     18
`define EIFL_HS_BASE        16'h0020
`define EIFL_HS_LAST        16'h0027
`define EIFL_SCI_STAT_ADDR  16'h0010
`define EIFL_SCI_DATA_ADDR  16'h0011
`define EIFL_TMR_W          8
`define EIFL_TMR_RST        8'h00
`define EIFL_TF_IC_LSB      0
`define EIFL_TF_PAI         3
`define EIFL_TF_GEN_LSB     4
`define EIFL_ESEL_OFF       2'h0
`define EIFL_ESEL_RISE      2'h1
`define EIFL_ESEL_FALL      2'h2
`define EIFL_ESEL_BOTH      2'h3

`endif

/* core/eifl_pkg.sv */
// Types for the maskable request and flag logic
package eifl_pkg;

    typedef logic [1:0] eifl_esel_t;

    typedef enum logic {
        OPT_OPEN,
        OPT_LOCKED
    } eifl_opt_st_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
    } eifl_acc_t;

    typedef struct packed {
        logic       shared;
        logic [2:0] ic;
        logic       pai;
        logic [3:0] tgen;
        logic       serial_comm_iface;
    } eifl_req_t;

endpackage : eifl_pkg

/* core/eifl_edge_det.sv */
// Selectable edge detector for one synchronous pin
`timescale 1ns/1ps
`include "eifl_cfg.svh"

module eifl_edge_det
    import eifl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pin,
    input  wire eifl_esel_t sel,
    output logic            evt_q
);

    logic prev_q;
    logic armed_q;
    wire  rise_w = pin & ~prev_q;
    wire  fall_w = ~pin & prev_q;
    // First cycle after reset only loads the pin history, so an idle-high pin gives no false edge
    wire  evt_d  = armed_q & (((sel == `EIFL_ESEL_RISE) & rise_w)
                 | ((sel == `EIFL_ESEL_FALL) & fall_w)
                 | ((sel == `EIFL_ESEL_BOTH) & (rise_w | fall_w)));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q  <= 1'b0;
            armed_q <= 1'b0;
            evt_q   <= 1'b0;
        end else begin
            prev_q  <= pin;
            armed_q <= 1'b1;
            evt_q   <= evt_d;
        end
    end

    chk_edge_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (sel == `EIFL_ESEL_OFF) |=> !evt_q)
        else $error("edge event while detector off");

endmodule : eifl_edge_det

/* core/eifl_top.sv */
// Maskable request pin, edge inputs and per-source flag logic
`timescale 1ns/1ps
`include "eifl_cfg.svh"

module eifl_top
    import eifl_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       irq_pin_n,
    input  wire logic                       nonmaskable_request_pin_n,
    input  wire logic                       edge_select_wr,
    input  wire logic                       edge_select_wdata,
    output logic                            edge_select_bit_q,
    input  wire logic                       i_mask,
    input  wire logic                       irq_taken,
    input  wire logic                       expanded_mode,
    input  wire eifl_acc_t                  cpu_acc,
    output logic [`EIFL_HS_PIN_CNT-1:0]     hs_pin_bus_q,
    output logic                            hs_ext_access_q,
    input  wire logic [2:0]                 input_capture_pins,
    input  wire eifl_esel_t [2:0]           ic_edge_sel,
    input  wire logic                       pai_pin,
    input  wire eifl_esel_t                 pai_edge_sel,
    input  wire logic                       strobe_a_pin,
    input  wire eifl_esel_t                 stra_edge_sel,
    input  wire logic                       stra_ie,
    input  wire logic                       stra_clr,
    output logic                            stra_flag_q,
    input  wire logic [3:0]                 timer_evt,
    input  wire logic [`EIFL_TMR_W-1:0]     tmr_ie,
    input  wire logic                       tmr_clr_wr,
    input  wire logic [`EIFL_TMR_W-1:0]     tmr_clr_data,
    output logic [`EIFL_TMR_W-1:0]          tmr_flags_q,
    input  wire logic                       rx_event,
    input  wire logic                       rx_ie,
    output logic                            rx_full_flag_q,
    output eifl_req_t                       req_q,
    output logic                            cpu_int_q,
    output logic                            nmi_req_q
);

    //------------------------------------------------------------
    // Reset release
    //------------------------------------------------------------
    logic rst_s1_q;
    logic rst_sn;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_sn   <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_sn   <= rst_s1_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sn);

    //------------------------------------------------------------
    // Time-protected edge select option
    //------------------------------------------------------------
    eifl_opt_st_t           opt_st_q;
    eifl_opt_st_t           opt_st_d;
    logic [`EIFL_CNT_W-1:0] opt_cnt_q;
    logic                   edge_sel_d;

    wire opt_open_w = (opt_st_q == OPT_OPEN);
    wire opt_last_w = (opt_cnt_q == `EIFL_OPT_WINDOW_CYC - 7'h01);
    wire opt_take_w = opt_open_w & edge_select_wr;

    always_comb begin
        opt_st_d   = opt_st_q;
        edge_sel_d = edge_select_bit_q;
        case (opt_st_q)
            OPT_OPEN: begin
                if (opt_take_w) begin
                    edge_sel_d = edge_select_wdata;
                    opt_st_d   = OPT_LOCKED;
                end else if (opt_last_w) begin
                    opt_st_d   = OPT_LOCKED;
                end
            end
            OPT_LOCKED: begin
                opt_st_d = OPT_LOCKED;
            end
            default: begin
                opt_st_d = OPT_LOCKED;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
            opt_st_q          <= OPT_OPEN;
            opt_cnt_q         <= '0;
            edge_select_bit_q <= `EIFL_OPT_RST;
        end else begin
            opt_st_q          <= opt_st_d;
            opt_cnt_q         <= opt_open_w ? opt_cnt_q + 7'h01 : opt_cnt_q;
            edge_select_bit_q <= edge_sel_d;
        end
    end

    chk_opt_locked_hold: assert property (
        (opt_st_q == OPT_LOCKED) |=> $stable(edge_select_bit_q))
        else $error("edge select changed after lock");

    chk_opt_window_len: assert property (
        opt_open_w |-> (opt_cnt_q < `EIFL_OPT_WINDOW_CYC))
        else $error("option window longer than allowed");

    //------------------------------------------------------------
    // External request pin
    //------------------------------------------------------------
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_prev_q;
    logic edge_lat_q;

    wire pin_fall_w = pin_prev_q & ~pin_s2_q;
    // Set wins over the vector-taken clear
    wire edge_lat_d = edge_select_bit_q & (pin_fall_w | (edge_lat_q & ~irq_taken));
    // Level mode follows the pin; edge mode only keeps the occurrence
    wire ext_req_w  = edge_select_bit_q ? edge_lat_q : ~pin_s2_q;

    always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
            pin_s1_q   <= 1'b1;
            pin_s2_q   <= 1'b1;
            pin_prev_q <= 1'b1;
            edge_lat_q <= 1'b0;
        end else begin
            pin_s1_q   <= irq_pin_n;
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
            edge_lat_q <= edge_lat_d;
        end
    end

    chk_edge_latch_set: assert property (
        (edge_select_bit_q && pin_prev_q && !pin_s2_q) |=> edge_lat_q)
        else $error("falling edge not latched");

    chk_edge_low_blind: assert property (
        (edge_select_bit_q && !pin_prev_q && !edge_lat_q) |=> !edge_lat_q)
        else $error("edge seen while pin held low");

    chk_edge_taken_clr: assert property (
        (edge_lat_q && irq_taken && !pin_fall_w) |=> !edge_lat_q)
        else $error("latched edge kept after vector taken");

    chk_level_follow: assert property (
        (!edge_select_bit_q && !pin_s2_q) |=> req_q.shared)
        else $error("low level did not request");

    //------------------------------------------------------------
    // Edge-sensitive pins
    //------------------------------------------------------------
    logic [2:0] ic_evt;
    logic       pai_evt;
    logic       stra_evt;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ic
            eifl_edge_det u_ic (
                .clk   (clk),
                .rst_n (rst_sn),
                .pin   (input_capture_pins[gi]),
                .sel   (ic_edge_sel[gi]),
                .evt_q (ic_evt[gi])
            );
        end
    endgenerate

    eifl_edge_det u_pai (
        .clk   (clk),
        .rst_n (rst_sn),
        .pin   (pai_pin),
        .sel   (pai_edge_sel),
        .evt_q (pai_evt)
    );

    eifl_edge_det u_stra (
        .clk   (clk),
        .rst_n (rst_sn),
        .pin   (strobe_a_pin),
        .sel   (stra_edge_sel),
        .evt_q (stra_evt)
    );

    //------------------------------------------------------------
    // Strobe A handshake flag
    //------------------------------------------------------------
    wire stra_set_w  = stra_evt & ~expanded_mode;
    wire stra_flag_d = stra_set_w | (stra_flag_q & ~stra_clr);

    always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
            stra_flag_q <= 1'b0;
        end else begin
            stra_flag_q <= stra_flag_d;
        end
    end

    chk_stra_expanded: assert property (
        (expanded_mode && !stra_flag_q) |=> !stra_flag_q)
        else $error("strobe flag set in expanded mode");

    //------------------------------------------------------------
    // Timer flags, write one to clear
    //------------------------------------------------------------
    wire [`EIFL_TMR_W-1:0] tmr_set_w = {timer_evt, pai_evt, ic_evt};
    wire [`EIFL_TMR_W-1:0] tmr_clr_w = tmr_clr_wr ? tmr_clr_data : `EIFL_TMR_RST;
    // New events win over a clear in the same cycle
    wire [`EIFL_TMR_W-1:0] tmr_d     = (tmr_flags_q & ~tmr_clr_w) | tmr_set_w;

    always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
            tmr_flags_q <= `EIFL_TMR_RST;
        end else begin
            tmr_flags_q <= tmr_d;
        end
    end

    chk_tmr_zero_keep: assert property (
        tmr_clr_wr |=> ((tmr_flags_q & $past(tmr_flags_q) & ~$past(tmr_clr_data))
                        == ($past(tmr_flags_q) & ~$past(tmr_clr_data))))
        else $error("timer flag lost on zero write");

    chk_tmr_one_clear: assert property (
        tmr_clr_wr |=> ((tmr_flags_q & $past(tmr_clr_data) & ~$past(tmr_set_w)) == '0))
        else $error("timer flag kept after one write");

    //------------------------------------------------------------
    // Serial receive-full flag, two-step read clear
    //------------------------------------------------------------
    // Any read strobe counts, including the read phase of a clear instruction
    wire stat_rd_w = cpu_acc.rd & (cpu_acc.addr == `EIFL_SCI_STAT_ADDR);
    wire data_rd_w = cpu_acc.rd & (cpu_acc.addr == `EIFL_SCI_DATA_ADDR);
    logic rx_arm_q;

    wire rx_clr_w  = rx_arm_q & data_rd_w;
    wire rx_flag_d = rx_event | (rx_full_flag_q & ~rx_clr_w);
    wire rx_arm_d  = (stat_rd_w & rx_full_flag_q) | (rx_arm_q & ~data_rd_w);

    always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
            rx_full_flag_q <= 1'b0;
            rx_arm_q       <= 1'b0;
        end else begin
            rx_full_flag_q <= rx_flag_d;
            rx_arm_q       <= rx_arm_d;
        end
    end

    chk_rx_two_step: assert property (
        (rx_arm_q && data_rd_w && !rx_event) |=> !rx_full_flag_q)
        else $error("receive flag not cleared by read pair");

    chk_rx_needs_stat: assert property (
        (!rx_arm_q && !stat_rd_w && rx_full_flag_q) |=> rx_full_flag_q)
        else $error("receive flag cleared without status read");

    //------------------------------------------------------------
    // Per-source requests and global mask
    //------------------------------------------------------------
    eifl_req_t req_d;

    // Shared vector: request pin and strobe A handshake
    assign req_d.shared = ext_req_w | (stra_flag_q & stra_ie);
    assign req_d.ic     = tmr_flags_q[`EIFL_TF_IC_LSB +: 3] & tmr_ie[`EIFL_TF_IC_LSB +: 3];
    assign req_d.pai    = tmr_flags_q[`EIFL_TF_PAI] & tmr_ie[`EIFL_TF_PAI];
    assign req_d.tgen   = tmr_flags_q[`EIFL_TF_GEN_LSB +: 4] & tmr_ie[`EIFL_TF_GEN_LSB +: 4];
    assign req_d.serial_comm_iface    = rx_full_flag_q & rx_ie;

    // Requests stay pending under the mask; only the CPU line is gated
    wire int_d = (|req_d) & ~i_mask;

    always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
            req_q     <= '0;
            cpu_int_q <= 1'b0;
            nmi_req_q <= 1'b0;
        end else begin
            req_q     <= req_d;
            cpu_int_q <= int_d;
            nmi_req_q <= ~nonmaskable_request_pin_n;
        end
    end

    chk_mask_inhibit: assert property (
        i_mask |=> !cpu_int_q)
        else $error("request passed global mask");

    chk_mask_pending: assert property (
        (i_mask && rx_full_flag_q && rx_ie) |=> (req_q.serial_comm_iface && !cpu_int_q))
        else $error("masked request not held pending");

    chk_enable_gate: assert property (
        !tmr_ie[`EIFL_TF_PAI] |=> !req_q.pai)
        else $error("disabled source requested");

    chk_flag_request: assert property (
        (rx_full_flag_q && rx_ie && !i_mask) |=> (req_q.serial_comm_iface && cpu_int_q))
        else $error("enabled flag gave no request");

    chk_flag_withdraw: assert property (
        (!tmr_flags_q[`EIFL_TF_PAI]) |=> !req_q.pai)
        else $error("request stayed after flag clear");

    //------------------------------------------------------------
    // Expanded mode pin hand-over and address decode
    //------------------------------------------------------------
    wire hs_hit_w = (cpu_acc.addr >= `EIFL_HS_BASE) & (cpu_acc.addr <= `EIFL_HS_LAST);
    wire hs_ext_d = expanded_mode & (cpu_acc.rd | cpu_acc.wr) & hs_hit_w;
    wire [`EIFL_HS_PIN_CNT-1:0] hs_pin_d = {`EIFL_HS_PIN_CNT{expanded_mode}};

    always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
            hs_pin_bus_q    <= '0;
            hs_ext_access_q <= 1'b0;
        end else begin
            hs_pin_bus_q    <= hs_pin_d;
            hs_ext_access_q <= hs_ext_d;
        end
    end

    chk_hs_ext_decode: assert property (
        (expanded_mode && cpu_acc.rd && hs_hit_w) |=> hs_ext_access_q)
        else $error("handshake address not sent external");

    chk_hs_single_int: assert property (
        !expanded_mode |=> !hs_ext_access_q)
        else $error("external access in single-chip mode");

    chk_hs_pins_bus: assert property (
        expanded_mode |=> (hs_pin_bus_q == {`EIFL_HS_PIN_CNT{1'b1}}))
        else $error("handshake pins not given to bus");

endmodule : eifl_top

/* bench/eifl_irq_src_model.sv */
// Model of the outside request sources and the port replacement unit on the request pin
`timescale 1ns/1ps

module eifl_irq_src_model (
    input  wire logic clk,
    input  wire logic ext_req,
    input  wire logic pru_req,
    input  wire logic pru_en,
    output logic      irq_pin_n
);
    logic ext_q;
    logic pru_q;

    initial begin
        ext_q = 1'b0;
        pru_q = 1'b0;
    end

    always @(posedge clk) begin
        ext_q <= ext_req;
        pru_q <= pru_req & pru_en;
    end

    // Open-drain wired-OR with a pull-up: released line reads high
    assign irq_pin_n = ~(ext_q | pru_q);
endmodule : eifl_irq_src_model

/* bench/eifl_top_tb.sv */
// Self-checking testbench of the maskable request and flag logic
`timescale 1ns/1ps
`include "eifl_cfg.svh"

module eifl_top_tb;
    import eifl_pkg::*;

    logic                         clk;
    logic                         rst_n;
    wire                          irq_pin_n;
    logic                         nmi_n, es_wr, es_wd, i_mask, irq_taken, exp_mode;
    logic                         ext_req, pru_req;
    eifl_acc_t                    acc;
    logic [2:0]                   icp;
    eifl_esel_t [2:0]             ic_sel;
    logic                         pai, stra, stra_ie, stra_clr, tclr_wr, rx_ev, rx_ie;
    eifl_esel_t                   pai_sel, stra_sel;
    logic [3:0]                   tevt;
    logic [7:0]                   tie, tclr_d, tflags;
    logic [`EIFL_HS_PIN_CNT-1:0]  hs_bus;
    logic                         es_bit, hs_ext, stra_flag, rx_flag, cpu_int, nmi_req;
    eifl_req_t                    req;
    int                           bad_count;
    int                           n_checks;

    eifl_irq_src_model u_src (.clk(clk), .ext_req(ext_req), .pru_req(pru_req), .pru_en(exp_mode),
        .irq_pin_n(irq_pin_n));

    eifl_top u_dut (.clk(clk), .rst_n(rst_n), .irq_pin_n(irq_pin_n), .nonmaskable_request_pin_n(nmi_n),
        .edge_select_wr(es_wr), .edge_select_wdata(es_wd), .edge_select_bit_q(es_bit), .i_mask(i_mask),
        .irq_taken(irq_taken), .expanded_mode(exp_mode), .cpu_acc(acc), .hs_pin_bus_q(hs_bus),
        .hs_ext_access_q(hs_ext), .input_capture_pins(icp), .ic_edge_sel(ic_sel), .pai_pin(pai),
        .pai_edge_sel(pai_sel), .strobe_a_pin(stra), .stra_edge_sel(stra_sel), .stra_ie(stra_ie),
        .stra_clr(stra_clr), .stra_flag_q(stra_flag), .timer_evt(tevt), .tmr_ie(tie),
        .tmr_clr_wr(tclr_wr), .tmr_clr_data(tclr_d), .tmr_flags_q(tflags), .rx_event(rx_ev),
        .rx_ie(rx_ie), .rx_full_flag_q(rx_flag), .req_q(req), .cpu_int_q(cpu_int), .nmi_req_q(nmi_req));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    //--------------------------------------------------------
    // Tasks
    //--------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_vec(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk_vec

    // One bus cycle; returns at the edge after it, where its registered effect shows
    task automatic access(input logic [15:0] addr, input logic rd, input logic wr);
        acc = '{addr: addr, rd: rd, wr: wr};
        tick(1);
        acc = '{addr: 16'h0000, rd: 1'b0, wr: 1'b0};
    endtask : access

    task automatic opt_write(input logic v);
        es_wd = v;
        es_wr = 1'b1;
        tick(1);
        es_wr = 1'b0;
        tick(1);
    endtask : opt_write

    task automatic do_reset;
        rst_n = 1'b0;
        tick(4);
        rst_n = 1'b1;
        tick(3);
    endtask : do_reset

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    //--------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------
    initial begin
        bad_count = 0; n_checks = 0;
        rst_n = 1'b0; nmi_n = 1'b1; es_wr = 1'b0; es_wd = 1'b0; i_mask = 1'b0; irq_taken = 1'b0;
        exp_mode = 1'b0; ext_req = 1'b0; pru_req = 1'b0; acc = '0; icp = 3'b010;
        ic_sel = {`EIFL_ESEL_BOTH, `EIFL_ESEL_FALL, `EIFL_ESEL_RISE}; pai = 1'b1;
        pai_sel = `EIFL_ESEL_FALL; stra = 1'b1; stra_sel = `EIFL_ESEL_FALL; stra_ie = 1'b0;
        stra_clr = 1'b0; tevt = 4'h0; tie = 8'h00; tclr_wr = 1'b0; tclr_d = 8'h00;
        rx_ev = 1'b0; rx_ie = 1'b0;
        do_reset();
        chk_bit(es_bit, 1'b0);
        tick(70);
        opt_write(1'b1);
        chk_bit(es_bit, 1'b0);
        // Level sensing, mask and pending
        ext_req = 1'b1; tick(6);
        chk_bit(req.shared, 1'b1);
        chk_bit(cpu_int, 1'b1);
        i_mask = 1'b1; tick(3);
        chk_bit(cpu_int, 1'b0);
        chk_bit(req.shared, 1'b1);
        i_mask = 1'b0; tick(3);
        chk_bit(cpu_int, 1'b1);
        ext_req = 1'b0; tick(6);
        chk_bit(req.shared, 1'b0);
        // Expanded mode: replacement unit and decode
        exp_mode = 1'b1; pru_req = 1'b1; tick(6);
        chk_bit(req.shared, 1'b1);
        chk_vec(hs_bus, {`EIFL_HS_PIN_CNT{1'b1}});
        pru_req = 1'b0;
        access(`EIFL_HS_BASE, 1'b1, 1'b0);
        chk_bit(hs_ext, 1'b1);
        tick(1);
        chk_bit(hs_ext, 1'b0);
        access(`EIFL_HS_LAST, 1'b0, 1'b1);
        chk_bit(hs_ext, 1'b1);
        tick(1);
        access(`EIFL_HS_LAST + 16'h0001, 1'b1, 1'b0);
        chk_bit(hs_ext, 1'b0);
        stra = 1'b0; tick(4);
        chk_bit(stra_flag, 1'b0);
        exp_mode = 1'b0; stra = 1'b1; tick(2);
        chk_vec(hs_bus, 18'h00000);
        access(`EIFL_HS_BASE, 1'b1, 1'b0);
        chk_bit(hs_ext, 1'b0);
        // Strobe A on the shared request
        stra = 1'b0; tick(4);
        chk_bit(stra_flag, 1'b1);
        chk_bit(req.shared, 1'b0);
        stra_ie = 1'b1; tick(3);
        chk_bit(req.shared, 1'b1);
        stra_clr = 1'b1; tick(1); stra_clr = 1'b0; tick(3);
        chk_bit(req.shared, 1'b0);
        // Timer flags, enables and write-one-to-clear
        tie = 8'hF0; tevt = 4'h1; tick(1); tevt = 4'h0; tick(3);
        chk_vec(tflags, 18'h10);
        chk_vec(req.tgen, 18'h1);
        tie = 8'h00; tick(2);
        chk_vec(req.tgen, 18'h0);
        tclr_d = 8'hEF; tclr_wr = 1'b1; tick(1); tclr_wr = 1'b0; tick(2);
        chk_vec(tflags, 18'h10);
        tclr_d = 8'h10; tclr_wr = 1'b1; tick(1); tclr_wr = 1'b0; tick(2);
        chk_vec(tflags, 18'h00);
        // Capture and accumulator pins, each with its own edge
        tie = 8'h0F; icp = 3'b101; pai = 1'b0; tick(5);
        chk_vec(tflags, 18'h0F);
        chk_vec({req.ic, req.pai}, 18'hF);
        tclr_d = 8'h0F; tclr_wr = 1'b1; tick(1); tclr_wr = 1'b0;
        icp = 3'b010; tick(5);
        chk_vec(tflags, 18'h04);
        pai_sel = `EIFL_ESEL_OFF; pai = 1'b1; tick(3); pai = 1'b0; tick(3);
        chk_vec(tflags, 18'h04);
        // Receive flag two-step clear
        rx_ie = 1'b1; rx_ev = 1'b1; tick(1); rx_ev = 1'b0; tick(3);
        chk_bit(req.serial_comm_iface, 1'b1);
        access(`EIFL_SCI_DATA_ADDR, 1'b1, 1'b0); tick(2);
        chk_bit(rx_flag, 1'b1);
        access(`EIFL_SCI_STAT_ADDR, 1'b1, 1'b0); tick(2);
        access(`EIFL_SCI_DATA_ADDR, 1'b1, 1'b0); tick(2);
        chk_bit(rx_flag, 1'b0);
        chk_bit(req.serial_comm_iface, 1'b0);
        rx_ev = 1'b1; tick(1); rx_ev = 1'b0; tick(2);
        access(`EIFL_SCI_STAT_ADDR, 1'b1, 1'b0); tick(1);
        access(`EIFL_SCI_DATA_ADDR, 1'b1, 1'b0); tick(1);
        access(`EIFL_SCI_DATA_ADDR, 1'b0, 1'b1); tick(2);
        chk_bit(rx_flag, 1'b0);
        nmi_n = 1'b0; tick(2);
        chk_bit(nmi_req, 1'b1);
        nmi_n = 1'b1;
        //----------------------------------------------------
        // Falling-edge mode
        //----------------------------------------------------
        do_reset();
        opt_write(1'b1);
        chk_bit(es_bit, 1'b1);
        opt_write(1'b0);
        chk_bit(es_bit, 1'b1);
        ext_req = 1'b1; tick(6);
        chk_bit(req.shared, 1'b1);
        irq_taken = 1'b1; tick(1); irq_taken = 1'b0; tick(3);
        chk_bit(req.shared, 1'b0);
        exp_mode = 1'b1; ext_req = 1'b0; tick(6);
        pru_req = 1'b1; tick(6);
        chk_bit(req.shared, 1'b1);
        irq_taken = 1'b1; tick(1); irq_taken = 1'b0;
        ext_req = 1'b1; tick(6);
        chk_bit(req.shared, 1'b0);
        pru_req = 1'b0; ext_req = 1'b0; tick(4); ext_req = 1'b1; tick(6);
        chk_bit(req.shared, 1'b1);
        do_reset();
        chk_bit(req.shared, 1'b0);
        chk_bit(es_bit, 1'b0);
        finish_test();
    end
endmodule : eifl_top_tb
